// ### analog_comparator_pair.sv
// behavioural model of the two analog comparator cores and input muxes
`timescale 1ns/10ps
`default_nettype none
module analog_comparator_pair
#(
    parameter logic [7:0] BANDGAP_LVL = 8'h60,
    parameter logic [7:0] MIDRAIL_LVL = 8'h80
)
(
    input  wire cmp_pkg::analog_cfg_s cfg_i,
    input  wire logic [63:0]          pins_i,
    output logic      [1:0]           result_o
);
    logic [7:0] pos0;
    logic [7:0] neg0;
    logic [7:0] neg1;
    // pins act as plain analog inputs here
    assign pos0 = pins_i[cfg_i.positive_pin_choice*8 +: 8];
    assign neg0 = cfg_i.ctl0.negative_input_choice ?
                  MIDRAIL_LVL : BANDGAP_LVL;
    assign neg1 = cfg_i.ctl1.negative_input_choice ?
                  BANDGAP_LVL : pins_i[55:48];
    // a disabled core still compares: the block must hide it
    assign result_o[0] = pos0 > neg0;
    assign result_o[1] = pins_i[63:56] > neg1;
endmodule // analog_comparator_pair
`default_nettype wire

// ### cmp_edge.sv
// change detector: compares sync value with its value one clock earlier
`timescale 1ns/10ps
`default_nettype none
module cmp_edge
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic level_i,
    output logic      change_o
);
    logic prev;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prev <= 1'b0;
        else
            prev <= level_i;
    end

    assign change_o = level_i ^ prev;
endmodule // cmp_edge
`default_nettype wire

// ### cmp_pkg.sv
// package: register map, field positions and carrier types for the comparator block
package cmp_pkg;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  OFF_CTRL0       = 4'h0;
    localparam logic [3:0]  OFF_CTRL1       = 4'h4;
    localparam logic [3:0]  OFF_STATE       = 4'h8;
    localparam logic [3:0]  OFF_POSITIVE_PIN_CHOICE      = 4'hC;
    localparam logic [3:0]  OFF_IRQ_MASK    = 4'h0;
    localparam int          BIT_ON          = 0;
    localparam int          BIT_IE          = 1;
    localparam int          BIT_NEG         = 4;
    localparam int          FLAG_LSB        = 0;
    localparam int          OUT_LSB         = 2;
    localparam int          POSITIVE_PIN_CHOICE_W        = 3;
    localparam int          NUM_CMP         = 2;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

    typedef struct packed {
        logic       negative_input_choice;
        logic       change_irq_enable;
        logic       comparator_on;
    } per_comparator_control_s;

    typedef struct packed {
        logic [POSITIVE_PIN_CHOICE_W-1:0]     positive_pin_choice;
        per_comparator_control_s ctl1;
        per_comparator_control_s ctl0;
    } analog_cfg_s;
endpackage

// ### cmp_sync.sv
// two-flop synchroniser for one comparator output, with enable gating
`timescale 1ns/10ps
`default_nettype none
module cmp_sync
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    input  wire logic enable_i,
    output logic      sync_o
);
    logic stage1;
    logic stage2;
    logic en1;
    logic en2;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end
        else
        begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    // enable travels beside the data so a config change makes one edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en1 <= 1'b0;
            en2 <= 1'b0;
        end
        else
        begin
            en1 <= enable_i;
            en2 <= en1;
        end
    end

    // a disabled comparator reads as zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sync_o <= 1'b0;
        else
            sync_o <= stage2 & en2;
    end
endmodule // cmp_sync
`default_nettype wire

// ### dual_comparator_control.sv
// dual analog comparator control, status and interrupt over Avalon-MM
// How it works
// R1: comparator high when positive input exceeds negative
// R2: two comparators, each with own change interrupt
// R3: one shared interrupt request output
// R4: three-bit field picks comparator 0 positive pin
// R5: comparator 0 bit 4: bandgap or mid-rail
// R6: comparator 1 bit 4: port pin or bandgap
// R7: control bit 1 enables comparator interrupt
// R8: control bit 0 enables the comparator
// R9: output change sets flag and requests interrupt (the flag is only set while the comparator interrupt is enabled)
// R10: writing one clears flag, zero leaves it
// R11: status shows each comparator current output
// R12: outputs synchronised, forced zero while disabled
// R13: registers at 0x00, 0x04, 0x08, 0x0C
// R14: software setup order before enabling
// R15: software configures analog pins first
// R16: change by compare to previous, OR gated flags
// R17: flag set beats same-cycle write-one clear
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module dual_comparator_control
(
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic [cmp_pkg::ADDR_W-1:0]    address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [31:0]                   writedata,
    input  wire logic [3:0]                    byteenable,
    output logic      [31:0]                   readdata,
    output logic                               waitrequest,
    input  wire logic [cmp_pkg::NUM_CMP-1:0]   cmp_result_i,
    output var cmp_pkg::analog_cfg_s           analog_cfg_o,
    output logic                               irq_o
);
    logic [cmp_pkg::NUM_CMP-1:0] cmp_sync;
    logic [cmp_pkg::NUM_CMP-1:0] cmp_change;
    logic [cmp_pkg::NUM_CMP-1:0] change_flag;
    logic [cmp_pkg::NUM_CMP-1:0] irq_en;
    logic [cmp_pkg::NUM_CMP-1:0] cmp_on;
    logic [cmp_pkg::NUM_CMP-1:0] on_seen;
    logic                        served;
    logic                        wr_go;
    logic                        rd_go;
    cmp_pkg::analog_cfg_s        cfg;

    // one wait state per access: answer on the second edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            waitrequest <= 1'b1;
        else
            waitrequest <= ~((read | write) & waitrequest);
    end

    assign served      = ~waitrequest;
    assign wr_go       = write & served & byteenable[0];
    assign rd_go       = read & served;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    // control and select registers, byte lane 0 only holds bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg <= '0; // [R13]
        else if (wr_go)
        begin
            if (hit(address, cmp_pkg::OFF_CTRL0))
            begin
                cfg.ctl0.comparator_on <=
                    writedata[cmp_pkg::BIT_ON]; // [R8]
                cfg.ctl0.change_irq_enable <=
                    writedata[cmp_pkg::BIT_IE]; // [R7]
                cfg.ctl0.negative_input_choice <=
                    writedata[cmp_pkg::BIT_NEG]; // [R5]
            end
            if (hit(address, cmp_pkg::OFF_CTRL1))
            begin
                cfg.ctl1.comparator_on <= writedata[cmp_pkg::BIT_ON];
                cfg.ctl1.change_irq_enable <= writedata[cmp_pkg::BIT_IE];
                cfg.ctl1.negative_input_choice <=
                    writedata[cmp_pkg::BIT_NEG]; // [R6]
            end
            if (hit(address, cmp_pkg::OFF_POSITIVE_PIN_CHOICE))
                cfg.positive_pin_choice <=
                    writedata[cmp_pkg::POSITIVE_PIN_CHOICE_W-1:0]; // [R4]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            analog_cfg_o <= '0;
        else
            analog_cfg_o <= cfg; // [R8] [R4]
    end

    assign cmp_on = {cfg.ctl1.comparator_on, cfg.ctl0.comparator_on};
    assign irq_en = {cfg.ctl1.change_irq_enable,
                     cfg.ctl0.change_irq_enable};
    // enable as the analog cores see it, aligned with their result
    assign on_seen = {analog_cfg_o.ctl1.comparator_on,
                      analog_cfg_o.ctl0.comparator_on};

    // per-comparator synchroniser and change detector
    genvar g;
    generate
        for (g = 0; g < cmp_pkg::NUM_CMP; g++)
        begin : g_cmp
            cmp_sync u_sync
            (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .async_i  (cmp_result_i[g]), // [R1]
                .enable_i (on_seen[g]),
                .sync_o   (cmp_sync[g])      // [R12]
            );
            cmp_edge u_edge
            (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .level_i  (cmp_sync[g]),
                .change_o (cmp_change[g])    // [R16]
            );

            // set has priority over a write-one clear
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    change_flag[g] <= 1'b0;
                else if (cmp_change[g] & irq_en[g])
                    change_flag[g] <= 1'b1; // [R9] [R17] [R2]
                else if (wr_go && hit(address, cmp_pkg::OFF_STATE)
                         && writedata[cmp_pkg::FLAG_LSB + g])
                    change_flag[g] <= 1'b0; // [R10]
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(change_flag & irq_en); // [R3] [R16]
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            readdata <= cmp_pkg::UNMAPPED_DATA;
        else if ((read | write) & ~served)
        begin
            readdata <= cmp_pkg::UNMAPPED_DATA;
            if (read)
            begin
                unique case (address)
                    cmp_pkg::OFF_CTRL0:
                        readdata[4:0] <= {cfg.ctl0.negative_input_choice,
                            2'h0, cfg.ctl0.change_irq_enable,
                            cfg.ctl0.comparator_on};
                    cmp_pkg::OFF_CTRL1:
                        readdata[4:0] <= {cfg.ctl1.negative_input_choice,
                            2'h0, cfg.ctl1.change_irq_enable,
                            cfg.ctl1.comparator_on};
                    cmp_pkg::OFF_STATE:
                        readdata[3:0] <= {cmp_sync, change_flag}; // [R11]
                    cmp_pkg::OFF_POSITIVE_PIN_CHOICE:
                        readdata[2:0] <= cfg.positive_pin_choice;
                    default:
                        readdata <= cmp_pkg::UNMAPPED_DATA;
                endcase
            end
        end
    end

    logic [cmp_pkg::NUM_CMP-1:0] past_sync;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            past_sync <= '0;
        else
            past_sync <= cmp_sync;
    end

    a_flag_on_change: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmp_sync[0] != past_sync[0]) && irq_en[0] |=> change_flag[0]) // [R9]
        else $error("flag 0 not set on change");
    a_set_beats_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_change[1] && irq_en[1] |=> change_flag[1]) // [R17]
        else $error("flag 1 lost to clear");
    a_clear_by_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && address == cmp_pkg::OFF_STATE && writedata[0]
        && !cmp_change[0] |=> !change_flag[0]) // [R10]
        else $error("flag 0 not cleared");
    a_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        change_flag[0] && !(wr_go && writedata[0]) |=> change_flag[0]) // [R10]
        else $error("flag 0 dropped");
    a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == $past(|(change_flag & irq_en))) // [R3]
        else $error("irq mismatch");
    a_off_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !cmp_on[1] [*5] |-> !cmp_sync[1]) // [R12]
        else $error("disabled output not zero");
    a_sync_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_on[0] [*5] |-> cmp_sync[0] == $past(cmp_result_i[0], 3)) // [R1]
        else $error("sync latency wrong");
    a_enable_out: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 analog_cfg_o.ctl0.comparator_on == $past(cmp_on[0])) // [R8]
        else $error("enable not driven");
    a_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (read | write) && waitrequest |=> !waitrequest) // [R13]
        else $error("wait state wrong");
    a_select_out: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 analog_cfg_o.positive_pin_choice
        == $past(cfg.positive_pin_choice)) // [R4]
        else $error("positive select not driven");
    a_neg1_out: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 analog_cfg_o.ctl1.negative_input_choice
        == $past(cfg.ctl1.negative_input_choice)) // [R6]
        else $error("negative select not driven");
    a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && address == cmp_pkg::OFF_STATE
        |-> readdata[3:0] == $past({cmp_sync, change_flag})) // [R11]
        else $error("status read wrong");
    c_irq_rise: cover property (@(posedge clk_i) disable iff (rst_i)
        !irq_o ##1 irq_o);
    c_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        change_flag[1] ##1 !change_flag[1]);
    c_both: cover property (@(posedge clk_i) disable iff (rst_i)
        &change_flag);
endmodule // dual_comparator_control
`default_nettype wire

// ### test_dual_comparator_control.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/10ps
`default_nettype none
module test_dual_comparator_control;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic [3:0]           address = 4'h0;
    logic                 read = 1'b0;
    logic                 write = 1'b0;
    logic [31:0]          writedata = 32'h0;
    logic [3:0]           byteenable = 4'hF;
    logic [31:0]          readdata;
    logic                 waitrequest;
    logic [1:0]           cmp_result;
    logic [63:0]          pins = 64'h0;
    cmp_pkg::analog_cfg_s analog_cfg;
    logic                 irq;
    int                   err_total = 0;
    int                   checks = 0;
    int                   seed = 33;
    int                   k;
    logic [31:0]          d;
    logic [31:0]          q;
    logic [4:0]           m_ctl [2];
    logic [2:0]           m_sel = 3'h0;
    logic [1:0]           m_prev = 2'h0;
    logic [1:0]           m_flag = 2'h0;

    always #2 clk_i = ~clk_i;

    dual_comparator_control u_dual_comparator_control (
        .clk_i(clk_i), .rst_i(rst_i), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .cmp_result_i(cmp_result), .analog_cfg_o(analog_cfg), .irq_o(irq));
    analog_comparator_pair u_analog_comparator_pair (
        .cfg_i(analog_cfg), .pins_i(pins), .result_o(cmp_result));

    task automatic final_report;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] dat, input logic [3:0] be);
        int n;
        @(posedge clk_i);
        address <= a;
        write <= w;
        read <= ~w;
        writedata <= dat;
        byteenable <= be;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
        begin
            err_total++;
            final_report();
        end
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    // reference outputs as software should see them
    function automatic logic [1:0] m_out();
        int p0;
        int n0;
        int n1;
        p0 = pins[m_sel*8 +: 8];
        n0 = m_ctl[0][4] ? 'h80 : 'h60;
        n1 = m_ctl[1][4] ? 'h60 : int'(pins[55:48]);
        m_out = {m_ctl[1][0] && int'(pins[63:56]) > n1, m_ctl[0][0] && p0 > n0};
    endfunction

    task automatic settle_check;
        logic [1:0] o;
        repeat (10) @(posedge clk_i);
        o = m_out();
        for (int n = 0; n < 2; n++)
            if (o[n] != m_prev[n] && m_ctl[n][1])
                m_flag[n] = 1'b1;
        m_prev = o;
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        chk(q, {28'h0, o, m_flag});
        chk({31'h0, irq}, {31'h0, |(m_flag & {m_ctl[1][1], m_ctl[0][1]})});
        chk({23'h0, analog_cfg}, {23'h0, m_sel, m_ctl[1][4], m_ctl[1][1:0],
            m_ctl[0][4], m_ctl[0][1:0]});
    endtask

    initial
    begin
        m_ctl[0] = 5'h0;
        m_ctl[1] = 5'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 16; i += 4)
        begin
            bus(1'b0, i[3:0], 32'h0, 4'hF);
            chk(q, 32'h0);
        end
        bus(1'b1, 4'h0, 32'h13, 4'h0);
        bus(1'b1, 4'h2, 32'h13, 4'hF);
        bus(1'b0, 4'h2, 32'h0, 4'hF);
        chk(q, 32'h0);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, 32'h0);
        for (int i = 0; i < 16; i += 4)
        begin
            if (i == 8)
                continue;
            bus(1'b1, i[3:0], 32'hFFFF_FFFF, 4'hF);
            bus(1'b0, i[3:0], 32'h0, 4'hF);
            chk(q, (i == 12) ? 32'h7 : 32'h13);
            bus(1'b1, i[3:0], 32'h0, 4'hF);
        end
        settle_check();
        for (int i = 0; i < 120; i++)
        begin
            k = $unsigned($random(seed)) % 5;
            d = $random(seed);
            case (k)
                0: begin
                    @(posedge clk_i);
                    pins <= {$random(seed), $random(seed)};
                end
                1, 2: begin
                    bus(1'b1, 4'(k * 4 - 4), d, 4'hF);
                    m_ctl[k-1] = d[4:0] & 5'h13;
                end
                3: begin
                    bus(1'b1, 4'hC, d, 4'hF);
                    m_sel = d[2:0];
                end
                default: begin
                    bus(1'b1, 4'h8, d, 4'hF);
                    m_flag = m_flag & ~d[1:0];
                end
            endcase
            settle_check();
        end
        final_report();
    end
endmodule // test_dual_comparator_control
`default_nettype wire
